// ### verilog/ccc_unit.sv
// Purpose: Four capture/compare channels with two timers, Avalon-MM
// Assumes: 125 MHz CLK, capture pins asynchronous to CLK
// Notes:   Every access waits exactly one cycle on waitrequest
`timescale 1ns/1ns

module ccc_unit #(
  parameter int TICK_DIV = 1
) (
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic [15:0] AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  input  wire logic [3:0]  CAP_IN,
  output logic      [3:0]  CMP_OUT,
  output logic             IRQ
);
  localparam int NCH = ccc_pkg::NCH;
  localparam int TW  = ccc_pkg::TW;
  localparam int IW  = ccc_pkg::IW;
  localparam int DW  = (TICK_DIV > 1) ? $clog2(TICK_DIV) : 1;

  // Divider must give at most one tick per cycle
  if (TICK_DIV < 1) begin : g_bad_div
    $error("TICK_DIV must be at least 1");
  end

  // Pin bus, status byte and mask byte are laid out for four channels
  if (NCH != 4) begin : g_bad_nch
    $error("Channel count must be 4 to match the pin and status layout");
  end

  // Byte-lane merge builds exactly 16 bits, so the time width is fixed
  if (TW != 16) begin : g_bad_tw
    $error("Time width must be 16 to match the byte-lane merge");
  end

  // Overrun bits sit directly above the per-channel event bits
  if (ccc_pkg::ST_OVR_LO != ccc_pkg::ST_EVT_LO + NCH) begin : g_bad_stat
    $error("Status layout must put overrun bits above event bits");
  end

  // Every control field must live in the low byte kept by all channels
  if (ccc_pkg::TB_BIT > 7) begin : g_bad_ctl
    $error("Control fields must fit in the low control byte");
  end

  // Register index must fit inside the byte address
  if (ccc_pkg::ADDR_LSB + IW > 16) begin : g_bad_idx
    $error("Register index does not fit the bus address");
  end

  ccc_pkg::ccc_bus_t       bus_state;
  logic [IW-1:0]           idx;
  logic                    req;
  logic                    acc_first;
  logic                    wr_do;
  logic [TW-1:0]           wmask;
  logic [NCH-1:0][TW-1:0]  ctl;
  logic [NCH-1:0][TW-1:0]  ch_time;
  logic [NCH-1:0]          ch_pop;
  logic [NCH-1:0]          ch_wr;
  logic [NCH-1:0]          cap_evt;
  logic [NCH-1:0]          cmp_evt;
  logic [NCH-1:0]          ovr_evt;
  logic [NCH-1:0]          cap_pulse;
  logic [NCH-1:0]          sync1;
  logic [NCH-1:0]          sync2;
  logic [NCH-1:0]          pin_q;
  logic [NCH-1:0]          clr_t1;
  logic [NCH-1:0]          clr_t2;
  logic [7:0]              status;
  logic [7:0]              mask;
  logic [7:0]              next_status;
  logic [7:0]              ev_set;
  logic [7:0]              w1c;
  logic [TW-1:0]           tmr1;
  logic [TW-1:0]           tmr2;
  logic [DW-1:0]           div_cnt;
  logic                    tick;
  logic [31:0]             next_rdata;

  ////////////////////////////////////////////////////////////////////
  // Avalon slave: one wait cycle per access. The first edge of a
  // request samples read data and pops a capture store, so the data
  // are settled a full cycle before the master takes them; a write
  // lands only on the second edge, when waitrequest is already low.
  assign idx       = AVS_ADDRESS[ccc_pkg::ADDR_LSB +: IW];
  assign req       = AVS_READ | AVS_WRITE;
  assign acc_first = req && (bus_state == ccc_pkg::CCC_BUS_IDLE);
  assign wr_do     = AVS_WRITE && (bus_state == ccc_pkg::CCC_BUS_ACK);
  assign AVS_WAITREQUEST = req && (bus_state != ccc_pkg::CCC_BUS_ACK);
  assign wmask = {{8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};

  // Idle takes the request, ack releases it on the next edge
  // A back-to-back request then sees one wait cycle again
  always_ff @(posedge CLK) begin
    if (RST) begin
      bus_state <= ccc_pkg::CCC_BUS_IDLE;
    end else begin
      case (bus_state)
        ccc_pkg::CCC_BUS_IDLE: begin
          if (req) begin
            bus_state <= ccc_pkg::CCC_BUS_ACK;
          end
        end
        ccc_pkg::CCC_BUS_ACK: begin
          bus_state <= ccc_pkg::CCC_BUS_IDLE;
        end
        default: begin
          bus_state <= ccc_pkg::CCC_BUS_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read mux; unmapped addresses read as zero
  // The map has no overlaps, so the order of the tests is moot
  // Time reads show the head of the capture store
  always_comb begin
    next_rdata = 32'h0000_0000;
    for (int i = 0; i < NCH; i++) begin
      if (idx == ccc_pkg::CTL_IDX[i]) begin
        next_rdata[TW-1:0] = ctl[i];
      end
      if (idx == ccc_pkg::TIME_IDX[i]) begin
        next_rdata[TW-1:0] = ch_time[i];
      end
    end
    if (idx == ccc_pkg::STAT_IDX) begin
      next_rdata[7:0] = status;
    end
    if (idx == ccc_pkg::MASK_IDX) begin
      next_rdata[7:0] = mask;
    end
    if (idx == ccc_pkg::TMR1_IDX) begin
      next_rdata[TW-1:0] = tmr1;
    end
    if (idx == ccc_pkg::TMR2_IDX) begin
      next_rdata[TW-1:0] = tmr2;
    end
  end

  // Data sampled on the first edge, stands until the next read
  // Sampling early keeps the pop and the returned value in step
  always_ff @(posedge CLK) begin
    if (RST) begin
      AVS_READDATA <= 32'h0000_0000;
    end else if (acc_first && AVS_READ) begin
      AVS_READDATA <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Capture pins: two-flop sync, then edge detect on the second flop
  // The edge copy resets low like an idle pin, so no false edge follows
  // Pulses shorter than one cycle may be missed by the sampler
  always_ff @(posedge CLK) begin
    if (RST) begin
      sync1 <= '0;
      sync2 <= '0;
      pin_q <= '0;
    end else begin
      sync1 <= CAP_IN;
      sync2 <= sync1;
      pin_q <= sync2;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Timer tick divider; a divide of one ticks every cycle
  // Both timers share it, so their counts never drift apart
  always_ff @(posedge CLK) begin
    if (RST) begin
      div_cnt <= '0;
    end else if (tick) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + 1'b1;
    end
  end
  assign tick = (TICK_DIV == 1) ||
                (div_cnt == DW'(TICK_DIV - 1));

  // Timers: a reset request beats the tick in the same cycle
  // Both wrap at full scale; no overflow flag is kept here
  // Several channels may ask for a reset at once; any one suffices
  always_ff @(posedge CLK) begin
    if (RST) begin
      tmr1 <= ccc_pkg::TIME_RST;
    end else if (|clr_t1) begin
      tmr1 <= ccc_pkg::TIME_RST;
    end else if (tick) begin
      tmr1 <= tmr1 + 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      tmr2 <= ccc_pkg::TIME_RST;
    end else if (|clr_t2) begin
      tmr2 <= ccc_pkg::TIME_RST;
    end else if (tick) begin
      tmr2 <= tmr2 + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Per-channel control, edge select, timer routing, channel core
  // Each slice reads its own control word and both timer counts
  // and hands the chosen reference count to its channel core
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    logic          cmode;
    logic          tb;
    logic          rise;
    logic          fall;
    logic [1:0]    edge_sel;
    logic [TW-1:0] ref_cnt;
    logic          rst_req;
    logic          hit_ref;

    assign cmode    = ctl[g][ccc_pkg::MODE_BIT];
    assign tb       = ctl[g][ccc_pkg::TB_BIT];
    assign edge_sel = ctl[g][ccc_pkg::EDGE_LO +: 2];
    assign rise     = sync2[g] & ~pin_q[g];
    assign fall     = ~sync2[g] & pin_q[g];
    assign ref_cnt  = tb ? tmr2 : tmr1;

    // Edge choice; code zero disables capture
    always_comb begin
      case (edge_sel)
        ccc_pkg::EDGE_RISE: cap_pulse[g] = rise;
        ccc_pkg::EDGE_FALL: cap_pulse[g] = fall;
        ccc_pkg::EDGE_BOTH: cap_pulse[g] = rise | fall;
        default:            cap_pulse[g] = 1'b0;
      endcase
    end

    // Compare resets a timer only with reset enabled; compare or
    // capture with the select bit set resets the opposite timer.
    // The target is the reference timer when hit_ref is high, else
    // the opposite one; the base bit says which timer that is, so
    // timer 1 is hit when exactly one of the two holds.
    assign rst_req = cmode ?
      (cmp_evt[g] & ctl[g][ccc_pkg::ON_RT_BIT]) :
      (cap_evt[g] & ctl[g][ccc_pkg::ROT_BIT]);
    assign hit_ref   = cmode & ~ctl[g][ccc_pkg::ROT_BIT];
    assign clr_t1[g] = rst_req & (hit_ref ^ tb);
    assign clr_t2[g] = rst_req & (hit_ref ~^ tb);

    // Register access strobes
    assign ch_pop[g] = acc_first && AVS_READ &&
                       (idx == ccc_pkg::TIME_IDX[g]);
    assign ch_wr[g]  = wr_do && (|AVS_BYTEENABLE[1:0]) &&
                       (idx == ccc_pkg::TIME_IDX[g]);

    // Control register, only implemented bits are writable
    // Channels 0 and 2 keep the low byte only; the upper byte of
    // channels 1 and 3 is plain storage with no effect here
    always_ff @(posedge CLK) begin
      if (RST) begin
        ctl[g] <= ccc_pkg::CTL_RST;
      end else if (wr_do && idx == ccc_pkg::CTL_IDX[g]) begin
        ctl[g] <= (ctl[g] & ~(wmask & ccc_pkg::CTL_MASK[g])) |
                  (AVS_WRITEDATA[TW-1:0] & wmask &
                   ccc_pkg::CTL_MASK[g]);
      end
    end

    // Write data merges the enabled lanes onto the current value,
    // so a single-byte write leaves the other byte untouched
    ccc_channel #(
      .TW (TW)
    ) u_chan (
      .clk       (CLK),
      .rst       (RST),
      .cmp_mode  (cmode),
      .on_rt     (ctl[g][ccc_pkg::ON_RT_BIT]),
      .cap_pulse (cap_pulse[g]),
      .ref_cnt   (ref_cnt),
      .pop       (ch_pop[g]),
      .wr_en     (ch_wr[g]),
      .wr_data   ((ch_time[g] & ~wmask) |
                  (AVS_WRITEDATA[TW-1:0] & wmask)),
      .time_q    (ch_time[g]),
      .cap_evt   (cap_evt[g]),
      .cmp_evt   (cmp_evt[g]),
      .ovr_evt   (ovr_evt[g])
    );
  end

  ////////////////////////////////////////////////////////////////////
  // Compare outputs: one-cycle registered pulses
  // Registered so the pins cannot glitch while the count settles
  always_ff @(posedge CLK) begin
    if (RST) begin
      CMP_OUT <= '0;
    end else begin
      CMP_OUT <= cmp_evt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Sticky status: write one to clear, a new event wins the clear
  // Bits 3:0 mark events per channel, bits 7:4 overruns per channel
  // Letting the event win means a clear never hides a fresh event
  assign ev_set = {ovr_evt, cap_evt | cmp_evt};
  assign w1c    = (wr_do && idx == ccc_pkg::STAT_IDX &&
                   AVS_BYTEENABLE[0]) ? AVS_WRITEDATA[7:0] : 8'h00;
  assign next_status = (status & ~w1c) | ev_set;

  always_ff @(posedge CLK) begin
    if (RST) begin
      status <= ccc_pkg::STAT_RST;
    end else begin
      status <= next_status;
    end
  end

  // Mask register, same layout as status
  always_ff @(posedge CLK) begin
    if (RST) begin
      mask <= ccc_pkg::STAT_RST;
    end else if (wr_do && idx == ccc_pkg::MASK_IDX &&
                 AVS_BYTEENABLE[0]) begin
      mask <= AVS_WRITEDATA[7:0];
    end
  end

  // Level interrupt; drops as soon as software clears the cause
  // It is combinational, so sample it on CLK only
  assign IRQ = |(status & mask);
endmodule : ccc_unit

// ### verilog/ccc_pkg.sv
// Purpose: Shared constants for the four-channel capture/compare unit
// Assumes: Avalon-MM byte addresses, register index times four
// Notes:   Printed offsets are register indices, not byte addresses
package ccc_pkg;
  localparam int NCH = 4;
  localparam int TW  = 16;
  localparam int IW  = 13;
  localparam int ADDR_LSB = 2;

  // Register indices; byte address is four times the index
  localparam logic [IW-1:0] CTL0_IDX  = 13'h1f80;
  localparam logic [IW-1:0] TIME0_IDX = 13'h1f82;
  localparam logic [IW-1:0] CTL1_IDX  = 13'h1f84;
  localparam logic [IW-1:0] TIME1_IDX = 13'h1f86;
  localparam logic [IW-1:0] CTL2_IDX  = 13'h1f88;
  localparam logic [IW-1:0] TIME2_IDX = 13'h1f8a;
  localparam logic [IW-1:0] CTL3_IDX  = 13'h1f8c;
  localparam logic [IW-1:0] TIME3_IDX = 13'h1f8e;
  localparam logic [IW-1:0] STAT_IDX  = 13'h1f90;
  localparam logic [IW-1:0] MASK_IDX  = 13'h1f92;
  localparam logic [IW-1:0] TMR1_IDX  = 13'h1f94;
  localparam logic [IW-1:0] TMR2_IDX  = 13'h1f96;

  localparam logic [NCH-1:0][IW-1:0] CTL_IDX =
    {CTL3_IDX, CTL2_IDX, CTL1_IDX, CTL0_IDX};
  localparam logic [NCH-1:0][IW-1:0] TIME_IDX =
    {TIME3_IDX, TIME2_IDX, TIME1_IDX, TIME0_IDX};
  // Channels 0 and 2 have 8-bit control registers
  localparam logic [NCH-1:0][TW-1:0] CTL_MASK =
    {16'hffff, 16'h00ff, 16'hffff, 16'h00ff};

  // Reset values
  localparam logic [TW-1:0] CTL_RST  = 16'h0000;
  localparam logic [TW-1:0] TIME_RST = 16'h0000;
  localparam logic [7:0]    STAT_RST = 8'h00;

  // Control fields
  localparam int ON_RT_BIT = 0;
  localparam int ROT_BIT   = 1;
  localparam int MODE_BIT  = 2;
  localparam int EDGE_LO   = 4;
  localparam int TB_BIT    = 7;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // Status and mask layout
  localparam int ST_EVT_LO = 0;
  localparam int ST_OVR_LO = 4;

  typedef enum logic [1:0] {
    CCC_BUS_IDLE = 2'b01,
    CCC_BUS_ACK  = 2'b10
  } ccc_bus_t;
endpackage : ccc_pkg

// ### verilog/ccc_channel.sv
// Purpose: One capture/compare channel with two-deep capture store
// Assumes: Edge pulse and timer values on the same clock
// Notes:   Compare mode uses the time register alone, no buffer
`timescale 1ns/1ns
module ccc_channel #(
  parameter int TW = 16
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          cmp_mode,
  input  wire logic          on_rt,
  input  wire logic          cap_pulse,
  input  wire logic [TW-1:0] ref_cnt,
  input  wire logic          pop,
  input  wire logic          wr_en,
  input  wire logic [TW-1:0] wr_data,
  output logic      [TW-1:0] time_q,
  output logic               cap_evt,
  output logic               cmp_evt,
  output logic               ovr_evt
);
  logic [TW-1:0] buf_q;
  logic          time_full;
  logic          buf_full;
  logic          eq_q;
  logic [TW-1:0] next_time;
  logic [TW-1:0] next_buf;
  logic          next_time_full;
  logic          next_buf_full;
  logic          eq;

  ////////////////////////////////////////////////////////////////////
  // Compare fires on the cycle the count becomes equal
  assign eq      = (ref_cnt == time_q);
  assign cmp_evt = cmp_mode & eq & ~eq_q;
  assign cap_evt = ~cmp_mode & cap_pulse;

  ////////////////////////////////////////////////////////////////////
  // Read pops first, so a capture in the same cycle finds room
  always_comb begin
    next_time      = time_q;
    next_buf       = buf_q;
    next_time_full = time_full;
    next_buf_full  = buf_full;
    ovr_evt        = 1'b0;
    if (pop && !cmp_mode) begin
      if (buf_full) begin
        next_time     = buf_q;
        next_buf_full = 1'b0;
      end else begin
        next_time_full = 1'b0;
      end
    end
    if (cap_evt) begin
      if (!next_time_full) begin
        next_time      = ref_cnt;
        next_time_full = 1'b1;
      end else if (!next_buf_full) begin
        next_buf      = ref_cnt;
        next_buf_full = 1'b1;
      end else begin
        ovr_evt = 1'b1;
        if (on_rt) begin
          next_buf = ref_cnt;
        end
      end
    end
    // Software write lands at once; no buffering in compare mode
    if (wr_en) begin
      next_time = wr_data;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Storage and fill flags
  always_ff @(posedge clk) begin
    if (rst) begin
      time_q    <= ccc_pkg::TIME_RST;
      buf_q     <= ccc_pkg::TIME_RST;
      time_full <= 1'b0;
      buf_full  <= 1'b0;
    end else begin
      time_q    <= next_time;
      buf_q     <= next_buf;
      time_full <= next_time_full;
      buf_full  <= next_buf_full;
    end
  end

  // Previous match, so a standing match fires only once
  always_ff @(posedge clk) begin
    if (rst) begin
      eq_q <= 1'b0;
    end else begin
      eq_q <= eq;
    end
  end
endmodule : ccc_channel

// ### bench/ccc_checker.sv
// Purpose: Port-level assertions for the capture/compare unit
// Assumes: One clock domain, synchronous active-high reset
// Notes:   Mask and mode live inside, so only port relations are checked
`timescale 1ns/1ns
module ccc_checker #(
  parameter int TICK_DIV = 1
) (
  input wire logic        CLK,
  input wire logic        RST,
  input wire logic [15:0] AVS_ADDRESS,
  input wire logic        AVS_READ,
  input wire logic        AVS_WRITE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic        AVS_WAITREQUEST,
  input wire logic [3:0]  CMP_OUT,
  input wire logic        IRQ
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  //////////////////////////////////////////////////////////////////////////
  // Bus transfer steps: opening cycle, then completion
  sequence s_req_open;
    $rose(AVS_READ || AVS_WRITE) ##0 AVS_WAITREQUEST;
  endsequence
  sequence s_rd_done;
    AVS_READ && !AVS_WAITREQUEST;
  endsequence

  property p_wait_first;
    $rose(AVS_READ || AVS_WRITE) |-> AVS_WAITREQUEST;
  endproperty
  property p_wait_one;
    s_req_open |=> !AVS_WAITREQUEST;
  endproperty
  property p_idle_nowait;
    !(AVS_READ || AVS_WRITE) |-> !AVS_WAITREQUEST;
  endproperty
  property p_rd_hold;
    !AVS_READ |=> $stable(AVS_READDATA);
  endproperty
  property p_upper_zero;
    s_rd_done |-> AVS_READDATA[31:16] == 16'h0000;
  endproperty
  property p_unmapped;
    s_rd_done ##0 (AVS_ADDRESS == 16'h0000) |-> AVS_READDATA == 32'h0000_0000;
  endproperty
  // A persisting match must not stretch the pulse
  property p_cmp_pulse;
    |CMP_OUT |=> (CMP_OUT & $past(CMP_OUT)) == 4'h0;
  endproperty
  // Reset must quiet outputs even though other checks are disabled then
  property p_rst_quiet;
    disable iff (1'b0) RST |=> (CMP_OUT == 4'h0) && !IRQ;
  endproperty

  a_wait_first:  assert property (p_wait_first) else $error("waitrequest low at request start");
  a_wait_one:    assert property (p_wait_one) else $error("more than one wait cycle");
  a_idle_nowait: assert property (p_idle_nowait) else $error("waitrequest high while idle");
  a_rd_hold:     assert property (p_rd_hold) else $error("read data changed without read");
  a_upper_zero:  assert property (p_upper_zero) else $error("read data upper half not zero");
  a_unmapped:    assert property (p_unmapped) else $error("unmapped read not zero");
  a_cmp_pulse:   assert property (p_cmp_pulse) else $error("compare pulse too long");
  a_rst_quiet:   assert property (p_rst_quiet) else $error("outputs active after reset");
endmodule : ccc_checker

bind ccc_unit ccc_checker #(.TICK_DIV(TICK_DIV)) i_chk (
  .CLK(CLK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
  .AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .CMP_OUT(CMP_OUT), .IRQ(IRQ));

// ### bench/ccc_tb.sv
// Purpose: Self-checking bench for the capture/compare unit
// Assumes: TICK_DIV of 1, so the reference timer steps once per cycle
// Notes:   Timer phase is unknown, so captures are checked as differences
`timescale 1ns/1ns
module testbench;
  localparam int          LIMIT  = 20000;
  localparam logic [15:0] A_CTL0 = 16'h7e00;
  localparam logic [15:0] A_TIM0 = 16'h7e08;
  localparam logic [15:0] A_CTL1 = 16'h7e10;
  localparam logic [15:0] A_TIM1 = 16'h7e18;
  localparam logic [15:0] A_STAT = 16'h7e40;
  localparam logic [15:0] A_MASK = 16'h7e48;
  localparam logic [15:0] A_TMR1 = 16'h7e50;
  localparam logic [15:0] A_TMR2 = 16'h7e58;
  logic        CLK, RST, AVS_READ, AVS_WRITE, AVS_WAITREQUEST, IRQ;
  logic [15:0] AVS_ADDRESS;
  logic [31:0] AVS_WRITEDATA, AVS_READDATA, v, w;
  logic [3:0]  CAP_IN, CMP_OUT;
  logic [63:0] rdq[$];
  logic [63:0] q;
  int          error_cnt, checks, seed, t0, t1;
  int          cyc = 0;

  ccc_unit #(.TICK_DIV(1)) i_dut (
    .CLK(CLK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(4'hf),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .CAP_IN(CAP_IN), .CMP_OUT(CMP_OUT), .IRQ(IRQ));

  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic final_report();
    if (error_cnt == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report

  // Request held until waitrequest is seen low at an edge
  task automatic bus_wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge CLK);
    AVS_ADDRESS   <= a;
    AVS_WRITEDATA <= d;
    AVS_WRITE     <= 1'b1;
    do @(posedge CLK); while (AVS_WAITREQUEST !== 1'b0);
    AVS_WRITE <= 1'b0;
  endtask : bus_wr

  // Expectation is queued; a zero mask means the value is only fetched
  task automatic bus_rd(input logic [15:0] a, input logic [31:0] m, input logic [31:0] e,
                        output logic [31:0] rd);
    rdq.push_back({m, e});
    @(posedge CLK);
    AVS_ADDRESS <= a;
    AVS_READ    <= 1'b1;
    do @(posedge CLK); while (AVS_WAITREQUEST !== 1'b0);
    rd = AVS_READDATA;
    AVS_READ <= 1'b0;
  endtask : bus_rd

  // Pulses on channel 1 every 8 cycles, then time for the sync chain
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge CLK);
      CAP_IN[1] <= 1'b1;
      repeat (4) @(posedge CLK);
      CAP_IN[1] <= 1'b0;
      repeat (3) @(posedge CLK);
    end
    repeat (6) @(posedge CLK);
  endtask : pulses

  task automatic irq_is(input logic e);
    @(posedge CLK);
    chk({31'h0, IRQ}, {31'h0, e});
  endtask : irq_is

  task automatic wait_pulse(output int at, input int lim);
    at = -1;
    for (int n = 0; n < lim && at < 0; n++) begin
      @(posedge CLK);
      if (CMP_OUT[0] === 1'b1) at = cyc;
    end
  endtask : wait_pulse

  // Three captures, third overruns; policy decides what the buffer keeps
  task automatic overrun(input logic on, input logic [31:0] gap);
    bus_wr(A_CTL1, {31'h8, on});
    pulses(3);
    bus_rd(A_STAT, 32'hff, 32'h22, v);
    bus_rd(A_TIM1, 32'h0, 32'h0, v);
    bus_rd(A_TIM1, 32'hffff, (v + gap) & 32'hffff, w);
    bus_wr(A_STAT, 32'hff);
  endtask : overrun

  //////////////////////////////////////////////////////////////////////////
  initial begin
    CLK = 1'b0;
    forever #4 CLK = ~CLK;
  end

  // Read checker and cycle ceiling; a hang ends the run as a failure
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (AVS_READ === 1'b1 && AVS_WAITREQUEST === 1'b0) begin
      q = rdq.pop_front();
      chk(AVS_READDATA & q[63:32], q[31:0]);
    end
    if (cyc >= LIMIT) begin
      error_cnt++;
      final_report();
    end
  end

  //////////////////////////////////////////////////////////////////////////
  initial begin
    seed          = 13;
    error_cnt     = 0;
    checks        = 0;
    RST           = 1'b1;
    AVS_READ      = 1'b0;
    AVS_WRITE     = 1'b0;
    AVS_ADDRESS   = 16'h0000;
    AVS_WRITEDATA = 32'h0;
    CAP_IN        = 4'h0;
    repeat (6) @(posedge CLK);
    RST <= 1'b0;
    // Reset values of control, time, status and mask
    for (int k = 0; k < 10; k++) bus_rd(A_CTL0 + 16'(8 * k), 32'hffffffff, 32'h0, v);
    // Control width per channel, time read-back, unmapped place
    for (int i = 0; i < 4; i++) begin
      w = $random(seed);
      bus_wr(A_CTL0 + 16'(16 * i), 32'ha5c3);
      bus_wr(A_TIM0 + 16'(16 * i), w);
      bus_rd(A_CTL0 + 16'(16 * i), 32'hffffffff, (i % 2) ? 32'ha5c3 : 32'hc3, v);
      bus_rd(A_TIM0 + 16'(16 * i), 32'hffffffff, w & 32'hffff, v);
    end
    bus_wr(16'h0000, 32'hffff);
    bus_rd(16'h0000, 32'hffffffff, 32'h0, v);
    overrun(1'b0, 32'd8);
    overrun(1'b1, 32'd16);
    // Interrupt raised, masked, unmasked, cleared
    bus_wr(A_MASK, 32'h02);
    pulses(1);
    irq_is(1'b1);
    bus_wr(A_MASK, 32'h00);
    irq_is(1'b0);
    bus_wr(A_MASK, 32'h02);
    irq_is(1'b1);
    bus_wr(A_STAT, 32'h02);
    irq_is(1'b0);
    bus_rd(A_TIM1, 32'h0, 32'h0, v);
    // Compare with timer reset; rewrite takes effect before the old match
    bus_rd(A_TMR1, 32'h0, 32'h0, v);
    bus_wr(A_TIM0, (v + 32'd60) & 32'hffff);
    bus_wr(A_CTL0, 32'h05);
    wait_pulse(t0, 200);
    bus_wr(A_TIM0, 32'd30);
    wait_pulse(t1, 200);
    chk(32'(t1 - t0), 32'd31);
    bus_wr(A_CTL0, 32'h07);
    wait_pulse(t0, 200);
    chk(32'(t0 - t1), 32'd31);
    bus_rd(A_TMR2, 32'hffff, 32'h2, v);
    bus_rd(A_STAT, 32'h01, 32'h01, v);
    wait_pulse(t1, 100);
    chk(32'(t1), 32'hffffffff);
    final_report();
  end
endmodule : testbench
